// file: gcl_gain_control.sv
`timescale 1ns/1ps
// What this block does
// - Digital ceiling n bars n top steps
// - Front ceiling code lowers combined front maximum
// - Target codes map 24..42 dB, reset 3
// - Loop compares filtered amplitude with target
// - Order one: lower first stage first
// - Order zero: second stage to minimum first
// - Relative threshold field bits 5:4, reset 0
// - Codes: off, 6, 10, 14 dB rise
module gcl_gain_control #(
   parameter int STEP_W = 3,
   parameter logic [2:0] DIG_TOP = 3'h7,
   parameter logic [2:0] STAGE_TOP = 3'h7
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic regWrEn,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   input wire logic ampValid,
   input wire logic [7:0] ampDb,
   input wire logic rssiValid,
   input wire logic [7:0] rssiDb,
   input wire logic carrierClear,
   output gcl_pkg::gcl_gain_type gainSet,
   output logic carrierSense,
   output logic [7:0] targetDb
);

   // =====================================================
   // Helper functions
   // =====================================================

   // Target amplitude in dB for a code; spacing narrows above code 4
   function automatic logic [7:0] target_db(input logic [2:0] code);
      logic [7:0] db;
      db = 8'h00;
      case (code)
         3'h0: db = 8'h18;
         3'h1: db = 8'h1b;
         3'h2: db = 8'h1e;
         3'h3: db = 8'h21;
         3'h4: db = 8'h24;
         3'h5: db = 8'h26;
         3'h6: db = 8'h28;
         default: db = 8'h2a;
      endcase
      return db;
   endfunction

   // Required rise for a relative threshold code
   function automatic logic [7:0] rel_rise(input logic [1:0] code);
      logic [7:0] r;
      r = 8'h00;
      case (code)
         2'h1: r = gcl_pkg::REL_RISE_1;
         2'h2: r = gcl_pkg::REL_RISE_2;
         2'h3: r = gcl_pkg::REL_RISE_3;
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // =====================================================
   // Configuration registers
   // =====================================================
   gcl_pkg::gcl_cfg_type cfg_ff; // Live settings
   gcl_pkg::gcl_cfg_type nxt_cfg; // Next settings

   // Register write decode
   always_comb begin
      nxt_cfg = cfg_ff;
      if (regWrEn && regAddr == gcl_pkg::ADDR_LIMIT_TARGET) begin
         nxt_cfg.digCeiling = regWrData[gcl_pkg::DIG_CEIL_LSB +: 2];
         nxt_cfg.frontCeiling = regWrData[gcl_pkg::FRONT_CEIL_LSB +: 3];
         nxt_cfg.amplitudeTarget = regWrData[gcl_pkg::TARGET_LSB +: 3];
      end else if (regWrEn && regAddr == gcl_pkg::ADDR_STRATEGY) begin
         nxt_cfg.gainReductionOrder = regWrData[gcl_pkg::ORDER_BIT];
         nxt_cfg.relCarrierThreshold = regWrData[gcl_pkg::REL_THR_LSB +: 2];
         // Reserved bit is dropped here, nothing stores it
      end
   end

   // Settings flops with documented reset values
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         cfg_ff.digCeiling <= gcl_pkg::DIG_CEIL_RST;
         cfg_ff.frontCeiling <= gcl_pkg::FRONT_CEIL_RST;
         cfg_ff.amplitudeTarget <= gcl_pkg::TARGET_RST;
         cfg_ff.gainReductionOrder <= gcl_pkg::ORDER_RST;
         cfg_ff.relCarrierThreshold <= gcl_pkg::REL_THR_RST;
      end else begin
         cfg_ff <= nxt_cfg;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      regRdData = 8'h00;
      if (regAddr == gcl_pkg::ADDR_LIMIT_TARGET) begin
         regRdData = {cfg_ff.digCeiling, cfg_ff.frontCeiling, cfg_ff.amplitudeTarget};
      end else if (regAddr == gcl_pkg::ADDR_STRATEGY) begin
         regRdData = {1'b0, cfg_ff.gainReductionOrder, cfg_ff.relCarrierThreshold, 4'h0};
      end
   end

   // =====================================================
   // Gain loop
   // =====================================================
   gcl_pkg::gcl_gain_type gain_ff; // Current stage steps
   gcl_pkg::gcl_gain_type nxt_gain; // Next stage steps
   logic [7:0] target_ff; // Registered target in dB
   logic [7:0] nxt_target;
   logic [2:0] digLimit; // Highest usable digital step
   logic [3:0] frontLimit; // Highest usable combined front step
   logic [3:0] frontSum; // Combined front step

   // Ceilings as step limits
   always_comb begin
      digLimit = DIG_TOP - {1'b0, cfg_ff.digCeiling};
      // Each code removes one combined front step
      frontLimit = {1'b0, STAGE_TOP} + {1'b0, STAGE_TOP} - {1'b0, cfg_ff.frontCeiling};
      frontSum = {1'b0, gain_ff.frontStage1} + {1'b0, gain_ff.frontStage2};
   end

   // One gain step per amplitude sample; ceiling clipping acts on every cycle, digital clip in one jump
   always_comb begin
      nxt_gain = gain_ff;
      // Code decoded to dB for comparison
      nxt_target = target_db(cfg_ff.amplitudeTarget);
      if (gain_ff.digitalAmp > digLimit) begin
         // Ceiling lowered under a running loop: clip at once
         nxt_gain.digitalAmp = digLimit;
      end else if (frontSum > frontLimit) begin
         // Clip the front pair, second stage gives way first
         if (gain_ff.frontStage2 != 3'h0) begin
            nxt_gain.frontStage2 = gain_ff.frontStage2 - 3'h1;
         end else begin
            nxt_gain.frontStage1 = gain_ff.frontStage1 - 3'h1;
         end
      end else if (ampValid && ampDb > target_ff) begin
         if (frontSum != 4'h0) begin
            if (cfg_ff.gainReductionOrder && gain_ff.frontStage1 != 3'h0) begin
               nxt_gain.frontStage1 = gain_ff.frontStage1 - 3'h1;
            // Second stage down to minimum first
            end else if (gain_ff.frontStage2 != 3'h0) begin
               nxt_gain.frontStage2 = gain_ff.frontStage2 - 3'h1;
            end else begin
               nxt_gain.frontStage1 = gain_ff.frontStage1 - 3'h1;
            end
         end else if (gain_ff.digitalAmp != 3'h0) begin
            nxt_gain.digitalAmp = gain_ff.digitalAmp - 3'h1;
         end
      end else if (ampValid && ampDb < target_ff) begin
         // Raise front gain first, same stage first as in the reduction order
         if (frontSum < frontLimit && gain_ff.frontStage2 < STAGE_TOP
             && (!cfg_ff.gainReductionOrder || gain_ff.frontStage1 == STAGE_TOP)) begin
            nxt_gain.frontStage2 = gain_ff.frontStage2 + 3'h1;
         end else if (frontSum < frontLimit && gain_ff.frontStage1 < STAGE_TOP) begin
            nxt_gain.frontStage1 = gain_ff.frontStage1 + 3'h1;
         end else if (frontSum < frontLimit && gain_ff.frontStage2 < STAGE_TOP) begin
            nxt_gain.frontStage2 = gain_ff.frontStage2 + 3'h1;
         end else if (gain_ff.digitalAmp < digLimit) begin
            nxt_gain.digitalAmp = gain_ff.digitalAmp + 3'h1;
         end
      end
   end

   // Gain and target flops; start at full gain
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         gain_ff <= '{digitalAmp: DIG_TOP, frontStage1: STAGE_TOP, frontStage2: STAGE_TOP};
         target_ff <= target_db(gcl_pkg::TARGET_RST);
      end else begin
         gain_ff <= nxt_gain;
         target_ff <= nxt_target;
      end
   end

   // =====================================================
   // Relative carrier sense
   // =====================================================
   logic [7:0] base_ff; // Signal level before the rise
   logic [7:0] nxt_base;
   logic cs_ff; // Carrier sense level
   logic nxt_cs;
   logic [8:0] riseMark; // Baseline plus required rise

   // Assert on a rise of the chosen size over the baseline
   always_comb begin
      nxt_base = base_ff;
      nxt_cs = cs_ff;
      riseMark = {1'b0, base_ff} + {1'b0, rel_rise(cfg_ff.relCarrierThreshold)};
      // Code zero disables the relative test
      if (cfg_ff.relCarrierThreshold == 2'h0) begin
         nxt_cs = 1'b0;
         if (rssiValid) begin
            nxt_base = rssiDb;
         end
      end else if (rssiValid && !cs_ff) begin
         // Rise of 6, 10 or 14 dB
         if ({1'b0, rssiDb} >= riseMark) begin
            nxt_cs = 1'b1;
         end else begin
            nxt_base = rssiDb;
         end
      end else if (carrierClear && !cs_ff) begin
         nxt_cs = 1'b0;
      end else if (carrierClear) begin
         // A set in the same cycle wins: the rise branch above is tested first
         nxt_cs = 1'b0;
         nxt_base = rssiDb;
      end
   end

   // Carrier sense flops
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         base_ff <= 8'hff;
         cs_ff <= 1'b0;
      end else begin
         base_ff <= nxt_base;
         cs_ff <= nxt_cs;
      end
   end

   assign gainSet = gain_ff;
   assign carrierSense = cs_ff;
   assign targetDb = target_ff;

endmodule

// file: gcl_gain_control_chk.sv
`timescale 1ns/1ps
// ==========
// Port-level checker for the gain limit block
module gcl_gain_control_chk #(
   parameter logic [2:0] DIG_TOP = 3'h7,
   parameter logic [2:0] STAGE_TOP = 3'h7
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic regWrEn,
   input wire logic [5:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic ampValid,
   input wire logic [7:0] ampDb,
   input wire logic rssiValid,
   input wire logic [7:0] rssiDb,
   input wire logic carrierClear,
   input wire gcl_pkg::gcl_gain_type gainSet,
   input wire logic carrierSense,
   input wire logic [7:0] targetDb
);
   // Shadow copies of both registers, rebuilt from the write port
   logic [7:0] limReg_ff, nxt_limReg, strReg_ff, nxt_strReg;
   logic [4:0] limD, limF, front, total;
   logic [7:0] tgtDb;
   logic noClip, redReq;
   // Next shadow values; unstored bits of the strategy byte dropped
   always_comb begin
      nxt_limReg = limReg_ff;
      nxt_strReg = strReg_ff;
      if (regWrEn && regAddr == gcl_pkg::ADDR_LIMIT_TARGET) begin
         nxt_limReg = regWrData;
      end
      if (regWrEn && regAddr == gcl_pkg::ADDR_STRATEGY) begin
         nxt_strReg = regWrData & 8'h70;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         limReg_ff <= 8'h03;
         strReg_ff <= 8'h40;
      end else begin
         limReg_ff <= nxt_limReg;
         strReg_ff <= nxt_strReg;
      end
   end
   // Ceilings in steps; front limit is one combined step per code
   assign limD = {2'b00, DIG_TOP} - {3'b000, limReg_ff[7:6]};
   assign limF = {1'b0, STAGE_TOP, 1'b0} - {2'b00, limReg_ff[5:3]};
   assign front = {2'b00, gainSet.frontStage1} + {2'b00, gainSet.frontStage2};
   assign total = {2'b00, gainSet.digitalAmp} + front;
   assign noClip = gainSet.digitalAmp <= limD && front <= limF;
   assign redReq = ampValid && noClip && ampDb > targetDb;
   // Target table: steps of 3 dB up to 36, then steps of 2
   assign tgtDb = (limReg_ff[2:0] < 3'h5) ? 8'h18 + 8'h03 * limReg_ff[2:0]
      : 8'h1c + 8'h02 * limReg_ff[2:0];
   // ==========
   // Assertions
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   property p_dig_clip;
      gainSet.digitalAmp > limD |=> gainSet.digitalAmp == $past(limD)
         && $stable(front);
   endproperty
   a_dig_clip: assert property (p_dig_clip) else $error("digital gain not clipped");
   property p_front_clip;
      gainSet.digitalAmp <= limD && front > limF |=> front == $past(front) - 5'h1;
   endproperty
   a_front_clip: assert property (p_front_clip) else $error("front gain not clipped");
   property p_target;
      1'b1 |=> targetDb == $past(tgtDb);
   endproperty
   a_target: assert property (p_target) else $error("target dB wrong");
   property p_rd_strategy;
      regAddr == gcl_pkg::ADDR_STRATEGY |-> regRdData == strReg_ff;
   endproperty
   a_rd_strategy: assert property (p_rd_strategy) else $error("strategy readback wrong");
   property p_reduce;
      redReq && total != 5'h0 |=> total == $past(total) - 5'h1;
   endproperty
   a_reduce: assert property (p_reduce) else $error("gain not reduced");
   property p_raise;
      ampValid && noClip && ampDb < targetDb && total < limD + limF |=> total == $past(total) + 5'h1;
   endproperty
   a_raise: assert property (p_raise) else $error("gain not raised");
   property p_order1;
      redReq && strReg_ff[6] && gainSet.frontStage1 != 3'h0 |=>
         gainSet.frontStage1 == $past(gainSet.frontStage1) - 3'h1 && $stable(gainSet.frontStage2);
   endproperty
   a_order1: assert property (p_order1) else $error("first stage not lowered first");
   property p_order0;
      redReq && !strReg_ff[6] && gainSet.frontStage2 != 3'h0 |=>
         gainSet.frontStage2 == $past(gainSet.frontStage2) - 3'h1 && $stable(gainSet.frontStage1);
   endproperty
   a_order0: assert property (p_order0) else $error("second stage not lowered first");
   property p_cs_cause;
      $rose(carrierSense) |-> $past(rssiValid) && $past(strReg_ff[5:4]) != 2'h0;
   endproperty
   a_cs_cause: assert property (p_cs_cause) else $error("carrier sense without cause");
   property p_cs_off;
      strReg_ff[5:4] == 2'h0 || (carrierClear && !(rssiValid && !carrierSense)) |=> !carrierSense;
   endproperty
   a_cs_off: assert property (p_cs_off) else $error("carrier sense not cleared");
   c_cs: cover property ($rose(carrierSense));
   c_reduce: cover property (redReq);
   c_clip: cover property (front > limF);
endmodule

// file: gcl_pkg.sv
// =====================================================
// Shared constants and types for the gain limit block
// =====================================================
package gcl_pkg;

   // Register addresses
   localparam logic [5:0] ADDR_LIMIT_TARGET = 6'h1b;
   localparam logic [5:0] ADDR_STRATEGY = 6'h1c;

   // Field positions, limit and target register
   localparam int DIG_CEIL_LSB = 6;
   localparam int FRONT_CEIL_LSB = 3;
   localparam int TARGET_LSB = 0;

   // Field positions, strategy register
   localparam int RESERVED_BIT = 7;
   localparam int ORDER_BIT = 6;
   localparam int REL_THR_LSB = 4;

   // Reset values
   localparam logic [1:0] DIG_CEIL_RST = 2'h0;
   localparam logic [2:0] FRONT_CEIL_RST = 3'h0;
   localparam logic [2:0] TARGET_RST = 3'h3;
   localparam logic ORDER_RST = 1'b1;
   localparam logic [1:0] REL_THR_RST = 2'h0;

   // Relative carrier-sense rise in dB per code, code 0 disables
   localparam logic [7:0] REL_RISE_1 = 8'h06;
   localparam logic [7:0] REL_RISE_2 = 8'h0a;
   localparam logic [7:0] REL_RISE_3 = 8'h0e;

   // Settings decoded from both registers
   typedef struct packed {
      logic [1:0] digCeiling;
      logic [2:0] frontCeiling;
      logic [2:0] amplitudeTarget;
      logic gainReductionOrder;
      logic [1:0] relCarrierThreshold;
   } gcl_cfg_type;

   // Gain setting of the three amplifier stages, in steps
   typedef struct packed {
      logic [2:0] digitalAmp;
      logic [2:0] frontStage1;
      logic [2:0] frontStage2;
   } gcl_gain_type;

endpackage

// file: testbench.sv
`timescale 1ns/1ps
// ==========
// Directed bench for the gain limit block
module testbench;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic regWrEn = 1'b0;
   logic [5:0] regAddr = 6'h00;
   logic [7:0] regWrData = 8'h00;
   logic [7:0] regRdData;
   logic ampValid = 1'b0;
   logic [7:0] ampDb = 8'h00;
   logic rssiValid = 1'b0;
   logic [7:0] rssiDb = 8'h00;
   logic carrierClear = 1'b0;
   gcl_pkg::gcl_gain_type gainSet;
   logic carrierSense;
   logic [7:0] targetDb;
   int error_cnt = 0;
   int checks_done = 0;
   logic [7:0] tgtTab [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
   logic [7:0] riseTab [4] = '{8'h00, 8'h06, 8'h0a, 8'h0e};
   always #20 clk_sys = ~clk_sys;
   gcl_gain_control dut (.clk_sys(clk_sys), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr),
      .regWrData(regWrData), .regRdData(regRdData), .ampValid(ampValid), .ampDb(ampDb),
      .rssiValid(rssiValid), .rssiDb(rssiDb), .carrierClear(carrierClear), .gainSet(gainSet),
      .carrierSense(carrierSense), .targetDb(targetDb));
   task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // Every driver leaves a quiet cycle so no strobe toggles twice at once
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      cyc(1);
      regWrEn = 1'b0;
      cyc(1);
   endtask
   // Address moves on the falling edge; readback is checked one cycle later, settled
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      regAddr = a;
      cyc(1);
      chk("regRdData", {1'b0, regRdData}, {1'b0, exp});
   endtask
   task automatic amp(input logic [7:0] v);
      ampDb = v;
      ampValid = 1'b1;
      cyc(1);
      ampValid = 1'b0;
      cyc(1);
   endtask
   task automatic rssi(input logic [7:0] v);
      rssiDb = v;
      rssiValid = 1'b1;
      cyc(1);
      rssiValid = 1'b0;
      cyc(1);
   endtask
   task automatic test_done();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog, far beyond the roughly 90 cycles the tests need
   initial begin
      #100000;
      error_cnt++;
      test_done();
   end
   initial begin
      cyc(4);
      rst = 1'b0;
      rd(6'h1b, 8'h03);
      rd(6'h1c, 8'h40);
      rd(6'h1d, 8'h00);
      chk("gainSet", gainSet, 9'h1ff);
      chk("carrierSense", carrierSense, 1'b0);
      wr(6'h1c, 8'hff);
      rd(6'h1c, 8'h70);
      wr(6'h1c, 8'h40);
      for (int i = 0; i < 8; i++) begin
         wr(6'h1b, 8'(i));
         chk("targetDb", targetDb, tgtTab[i]);
      end
      amp(8'h32);
      chk("gainSet", gainSet, 9'h1f7);
      wr(6'h1c, 8'h00);
      amp(8'h32);
      chk("gainSet", gainSet, 9'h1f6);
      amp(8'h2a);
      chk("gainSet", gainSet, 9'h1f6);
      amp(8'h0a);
      chk("gainSet", gainSet, 9'h1f7);
      wr(6'h1b, 8'hc7);
      cyc(6);
      chk("digitalAmp", gainSet.digitalAmp, 3'h4);
      wr(6'h1b, 8'h3f);
      cyc(10);
      chk("frontSum", gainSet.frontStage1 + gainSet.frontStage2, 9'h007);
      // Exact threshold: one dB short must not trigger
      for (int c = 1; c < 4; c++) begin
         wr(6'h1c, {2'b00, 2'(c), 4'h0});
         rssi(8'h14);
         rssi(8'h13 + riseTab[c]);
         chk("carrierSense", carrierSense, 1'b0);
         rssi(8'h13 + 8'h02 * riseTab[c]);
         chk("carrierSense", carrierSense, 1'b1);
         carrierClear = 1'b1;
         cyc(1);
         carrierClear = 1'b0;
         chk("carrierSense", carrierSense, 1'b0);
      end
      // Mid-run reset must bring every setting back
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      rd(6'h1b, 8'h03);
      rd(6'h1c, 8'h40);
      chk("gainSet", gainSet, 9'h1ff);
      chk("targetDb", targetDb, tgtTab[3]);
      chk("carrierSense", carrierSense, 1'b0);
      test_done();
   end
endmodule
bind gcl_gain_control gcl_gain_control_chk #(.DIG_TOP(DIG_TOP), .STAGE_TOP(STAGE_TOP)) u_chk (
   .clk_sys(clk_sys), .rst(rst), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
   .regRdData(regRdData), .ampValid(ampValid), .ampDb(ampDb), .rssiValid(rssiValid),
   .rssiDb(rssiDb), .carrierClear(carrierClear), .gainSet(gainSet),
   .carrierSense(carrierSense), .targetDb(targetDb));
